// >>> core/sensor_defines.svh
`ifndef SENSOR_DEFINES_SVH
`define SENSOR_DEFINES_SVH

// ************************************************************
// widths
// ************************************************************
`define MASK_W 16
`define TEMP_MASK_W 7
`define CHAN_W 4
`define VALUE_W 32
`define NUM_CHAN 16

// ************************************************************
// fixed-point formats
// ************************************************************
`define VOLT_FRAC_BITS 16
`define TEMP_FRAC_BITS 8

// ************************************************************
// reset values and temperature channel keep mask
// ************************************************************
`define MASK_RST 16'h0000
`define CHAN_RST 4'h0
`define VALUE_RST 32'h0000_0000
`define TEMP_MASK_KEEP 16'h007F

`endif

// >>> core/sensor_pkg.sv
`include "sensor_defines.svh"

package sensor_pkg;

   // ************************************************************
   // variants and states
   // ************************************************************
   typedef enum logic {
      KIND_VOLTAGE = 1'b0,
      KIND_TEMPERATURE = 1'b1
   } sensor_kind_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT_ACK = 2'b01,
      ST_FETCH = 2'b11,
      ST_SEND = 2'b10
   } ctrl_state_t;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic [`CHAN_W-1:0] channel;
      logic [`VALUE_W-1:0] value;
      logic first;
      logic last;
   } result_beat_t;

   typedef struct packed {
      logic [`CHAN_W-1:0] channel;
      logic [`VALUE_W-1:0] value;
   } refresh_t;

endpackage : sensor_pkg

// >>> core/sample_store.sv
`timescale 1ns/1ns
`include "sensor_defines.svh"

module sample_store (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // refresh write port
   input wire logic wr_en,
   input wire logic [`CHAN_W-1:0] wr_addr,
   input wire logic [`VALUE_W-1:0] wr_data,
   // read port
   input wire logic rd_en,
   input wire logic [`CHAN_W-1:0] rd_addr,
   output logic [`VALUE_W-1:0] rd_data
);

   logic [`VALUE_W-1:0] mem [0:`NUM_CHAN-1];

   // ************************************************************
   // latest reading per channel
   // ************************************************************
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_data <= `VALUE_RST;
      end else if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule : sample_store

// >>> core/sensor_sample_request_port.sv
`timescale 1ns/1ns
`include "sensor_defines.svh"

module sensor_sample_request_port (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // variant select
   input sensor_pkg::sensor_kind_t sensor_kind,
   // command stream
   input wire logic request_valid,
   output logic request_ready,
   input wire logic [`MASK_W-1:0] channel_mask,
   // response stream
   output logic result_valid,
   input wire logic result_ready,
   output sensor_pkg::result_beat_t result,
   // management processor link
   output logic mgr_req_valid,
   output logic [`MASK_W-1:0] mgr_req_mask,
   input wire logic mgr_req_ack,
   input wire logic refresh_valid,
   input sensor_pkg::refresh_t refresh
);

   import sensor_pkg::*;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [`CHAN_W-1:0] lowest_set(input logic [`MASK_W-1:0] m);
      logic [`CHAN_W-1:0] idx;
      idx = `CHAN_RST;
      for (int i = `NUM_CHAN - 1; i >= 0; i--) begin
         if (m[i]) begin
            idx = i[`CHAN_W-1:0];
         end
      end
      return idx;
   endfunction : lowest_set

   function automatic logic [`CHAN_W:0] count_set(input logic [`MASK_W-1:0] m);
      logic [`CHAN_W:0] n;
      n = '0;
      for (int i = 0; i < `NUM_CHAN; i++) begin
         n = n + {{`CHAN_W{1'b0}}, m[i]};
      end
      return n;
   endfunction : count_set

   ctrl_state_t state_reg;
   ctrl_state_t state_next;
   logic [`MASK_W-1:0] mask_reg;
   logic [`MASK_W-1:0] legal_mask;
   logic [`CHAN_W-1:0] chan_reg;
   logic first_reg;
   logic last_reg;
   logic accept;
   logic beat_done;
   logic fetch;
   logic [`CHAN_W-1:0] fetch_chan;
   logic [`MASK_W-1:0] mask_left;
   logic [`VALUE_W-1:0] store_data;

   // ************************************************************
   // handshakes
   // ************************************************************
   assign request_ready = (state_reg == ST_IDLE);
   assign accept = request_valid && request_ready;
   assign result_valid = (state_reg == ST_SEND);
   assign beat_done = result_valid && result_ready;
   assign mgr_req_valid = (state_reg == ST_WAIT_ACK);
   assign mgr_req_mask = mask_reg;
   assign fetch = (state_reg == ST_FETCH);
   assign fetch_chan = lowest_set(mask_reg);
   assign mask_left = mask_reg & ~(`MASK_W'(1) << fetch_chan);
   assign legal_mask = (sensor_kind == KIND_TEMPERATURE) ? (channel_mask & `TEMP_MASK_KEEP) : channel_mask;

   // ************************************************************
   // control state machine
   // ************************************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (accept) begin
               state_next = ST_WAIT_ACK;
            end
         end
         ST_WAIT_ACK: begin
            if (mgr_req_ack) begin
               state_next = (mask_reg == `MASK_RST) ? ST_IDLE : ST_FETCH;
            end
         end
         ST_FETCH: begin
            state_next = ST_SEND;
         end
         ST_SEND: begin
            if (beat_done) begin
               state_next = last_reg ? ST_IDLE : ST_FETCH;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ************************************************************
   // captured mask, walked lowest bit first
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mask_reg <= `MASK_RST;
      end else if (accept) begin
         mask_reg <= legal_mask;
      end else if (fetch) begin
         mask_reg <= mask_left;
      end
   end

   // ************************************************************
   // beat tags
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         chan_reg <= `CHAN_RST;
      end else if (fetch) begin
         chan_reg <= fetch_chan;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         last_reg <= 1'b0;
      end else if (fetch) begin
         last_reg <= (mask_left == `MASK_RST);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         first_reg <= 1'b0;
      end else if (accept) begin
         first_reg <= 1'b1;
      end else if (beat_done) begin
         first_reg <= 1'b0;
      end
   end

   // ************************************************************
   // stored readings
   // ************************************************************
   sample_store u_store (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(refresh_valid),
      .wr_addr(refresh.channel),
      .wr_data(refresh.value),
      .rd_en(fetch),
      .rd_addr(fetch_chan),
      .rd_data(store_data)
   );

   always_comb begin
      result.channel = chan_reg;
      result.value = store_data;
      result.first = first_reg && result_valid;
      result.last = last_reg && result_valid;
   end

   // ************************************************************
   // checks
   // ************************************************************
   logic [`MASK_W-1:0] acc_mask_reg;
   logic [`CHAN_W:0] beats_reg;
   logic [`CHAN_W-1:0] prev_chan_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc_mask_reg <= `MASK_RST;
      end else if (accept) begin
         acc_mask_reg <= legal_mask;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         beats_reg <= '0;
      end else if (accept) begin
         beats_reg <= '0;
      end else if (beat_done) begin
         beats_reg <= beats_reg + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev_chan_reg <= `CHAN_RST;
      end else if (beat_done) begin
         prev_chan_reg <= chan_reg;
      end
   end

   a_reset_idle: assert property (@(posedge clk) disable iff (1'b0)
      !rst_n |=> request_ready && !result_valid)
      else $error("not idle after reset");
   a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0)
      !rst_n |=> !mgr_req_valid && !result.first && !result.last)
      else $error("outputs not quiet after reset");
   a_ready_drop: assert property (accept |=>
      !request_ready ##1 !request_ready)
      else $error("ready did not drop after accept");
   a_ready_busy: assert property (request_ready |->
      !result_valid && !mgr_req_valid)
      else $error("ready while busy");
   a_accept_forward: assert property (accept |=> mgr_req_valid &&
      mgr_req_mask == ($past(channel_mask) & ($past(sensor_kind) == KIND_TEMPERATURE ? `TEMP_MASK_KEEP : {`MASK_W{1'b1}})))
      else $error("forwarded mask differs from command");
   a_wait_manager: assert property (mgr_req_valid && !mgr_req_ack |=>
      !result_valid && mgr_req_valid)
      else $error("beat before manager answer");
   a_first_after_ack: assert property (mgr_req_valid && mgr_req_ack && mgr_req_mask != `MASK_RST |=>
      !result_valid ##1 result_valid && result.first)
      else $error("first beat not two cycles after answer");
   a_empty_mask: assert property (mgr_req_valid && mgr_req_ack && mgr_req_mask == `MASK_RST |=>
      request_ready && !result_valid)
      else $error("empty mask produced a beat");
   a_result_hold: assert property (result_valid && !result_ready |=>
      result_valid && $stable(result))
      else $error("result changed while stalled");
   a_beat_gap: assert property (beat_done && !result.last |=>
      !result_valid ##1 result_valid && !result.first)
      else $error("next beat not after one fetch cycle");
   a_ready_return: assert property (beat_done && result.last |=>
      request_ready)
      else $error("ready not back after last");
   a_valid_tags: assert property (!result_valid |->
      !result.first && !result.last)
      else $error("packet flag without valid");
   a_first_beat: assert property (result_valid |->
      (result.first == (beats_reg == '0)))
      else $error("first flag misplaced");
   a_beat_count: assert property (beat_done |->
      (result.last == (beats_reg + 1'b1 == count_set(acc_mask_reg))))
      else $error("beat count differs from mask");
   a_chan_in_mask: assert property (result_valid |->
      acc_mask_reg[result.channel])
      else $error("channel not requested");
   a_ascending: assert property (result_valid && !result.first |->
      result.channel > prev_chan_reg)
      else $error("channels not ascending");
   a_first_lowest: assert property (result_valid && result.first |->
      (acc_mask_reg & ((`MASK_W'(1) << result.channel) - `MASK_W'(1))) == `MASK_RST)
      else $error("first beat not lowest channel");
   a_last_highest: assert property (result_valid && result.last |->
      (acc_mask_reg >> result.channel) == `MASK_W'(1))
      else $error("last beat not highest channel");
   a_single_chan: assert property (result_valid && count_set(acc_mask_reg) == 1 |->
      result.first && result.last)
      else $error("single beat not first and last");
   a_temp_range: assert property (result_valid && sensor_kind == KIND_TEMPERATURE |->
      result.channel < 4'h7)
      else $error("temperature channel out of range");
   a_fetch_to_beat: assert property (fetch |=>
      result_valid && result.channel == $past(fetch_chan))
      else $error("fetch not followed by beat");

endmodule : sensor_sample_request_port

// >>> testbench/manager_model.sv
`timescale 1ns/1ns

module manager_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // manager link
   input wire logic mgr_req_valid,
   input wire logic [3:0] ack_wait,
   output logic mgr_req_ack,
   output logic refresh_valid,
   output sensor_pkg::refresh_t refresh
);
   import sensor_pkg::*;
   logic [4:0] wr_reg;
   logic [3:0] cnt_reg;
   // ****
   // one reading per channel after reset
   // ****
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_reg <= 5'h00;
         refresh_valid <= 1'b0;
         refresh <= '0;
      end else begin
         refresh_valid <= !wr_reg[4];
         refresh.channel <= wr_reg[3:0];
         refresh.value <= wr_reg[4] ? ~refresh.value : {12'h000, wr_reg[3:0], 16'hC000};
         if (!wr_reg[4]) begin
            wr_reg <= wr_reg + 5'h01;
         end
      end
   end
   // ****
   // ack after settable wait
   // ****
   always_ff @(posedge clk) begin
      if (!rst_n || !mgr_req_valid) begin
         cnt_reg <= 4'h0;
         mgr_req_ack <= 1'b0;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
         mgr_req_ack <= (cnt_reg == ack_wait) && !mgr_req_ack;
      end
   end
endmodule : manager_model

// >>> testbench/sensor_sample_request_port_tb.sv
`timescale 1ns/1ns
`include "sensor_defines.svh"

module sensor_sample_request_port_tb;
   import sensor_pkg::*;
   logic clk, rst_n, request_valid, request_ready, result_valid, result_ready;
   logic mgr_req_valid, mgr_req_ack, refresh_valid;
   logic [`MASK_W-1:0] channel_mask, mgr_req_mask;
   logic [3:0] ack_wait;
   sensor_kind_t sensor_kind;
   result_beat_t result;
   refresh_t refresh;
   int err_total = 0;
   int total_checks = 0;
   int cycles = 0;

   sensor_sample_request_port i_dut (.clk(clk), .rst_n(rst_n), .sensor_kind(sensor_kind),
      .request_valid(request_valid), .request_ready(request_ready), .channel_mask(channel_mask),
      .result_valid(result_valid), .result_ready(result_ready), .result(result),
      .mgr_req_valid(mgr_req_valid), .mgr_req_mask(mgr_req_mask), .mgr_req_ack(mgr_req_ack),
      .refresh_valid(refresh_valid), .refresh(refresh));
   manager_model i_mgr (.clk(clk), .rst_n(rst_n), .mgr_req_valid(mgr_req_valid), .ack_wait(ack_wait),
      .mgr_req_ack(mgr_req_ack), .refresh_valid(refresh_valid), .refresh(refresh));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // ****
   // report and compare
   // ****
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         err_total++;
         end_of_test();
      end
   end

   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_word

   task automatic chk_bit(input logic g, input logic e);
      chk_word({31'h0, g}, {31'h0, e});
   endtask : chk_bit
   // ****
   // one command and all its beats
   // ****
   task automatic run(input sensor_kind_t k, input logic [15:0] m, input int stall, input bit hold,
      input bit pre, input logic [3:0] aw);
      logic [15:0] e;
      int n;
      int w;
      e = (k == KIND_TEMPERATURE) ? (m & `TEMP_MASK_KEEP) : m;
      n = 0;
      @(posedge clk);
      ack_wait <= aw;
      if (!pre) begin
         sensor_kind <= k;
         channel_mask <= m;
         request_valid <= 1'b1;
         @(negedge clk);
         chk_bit(request_ready, 1'b1);
         @(posedge clk);
      end
      if (!hold) begin
         request_valid <= 1'b0;
      end
      @(negedge clk);
      chk_bit(mgr_req_valid, 1'b1);
      chk_word({16'h0000, mgr_req_mask}, {16'h0000, e});
      @(posedge clk);
      if (e == 16'h0000) begin
         repeat (int'(aw) + 3) @(posedge clk);
      end
      for (int ch = 0; ch < `NUM_CHAN; ch++) begin
         if (e[ch]) begin
            if (stall > 0) begin
               result_ready <= 1'b0;
               repeat (stall) @(posedge clk);
               result_ready <= 1'b1;
            end
            w = 0;
            @(negedge clk);
            while (result_valid !== 1'b1 && w < 20) begin
               @(negedge clk);
               w++;
            end
            chk_bit(result_valid, 1'b1);
            chk_bit(request_ready, 1'b0);
            chk_word({28'h0, result.channel}, ch);
            chk_word(result.value, {12'h000, ch[3:0], 16'hC000});
            chk_bit(result.first, n == 0);
            chk_bit(result.last, n == $countones(e) - 1);
            n++;
            @(posedge clk);
         end
      end
      @(negedge clk);
      chk_bit(result_valid, 1'b0);
      chk_bit(request_ready, 1'b1);
   endtask : run
   // ****
   // main sequence
   // ****
   initial begin
      rst_n = 1'b0;
      request_valid = 1'b0;
      channel_mask = 16'h0000;
      sensor_kind = KIND_VOLTAGE;
      result_ready = 1'b1;
      ack_wait = 4'h0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk_bit(request_ready, 1'b1);
      chk_bit(result_valid, 1'b0);
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (20) @(posedge clk);
      run(KIND_VOLTAGE, 16'h000B, 0, 0, 0, 4'h0);
      run(KIND_VOLTAGE, 16'h8000, 3, 0, 0, 4'h0);
      run(KIND_VOLTAGE, 16'h0000, 0, 0, 0, 4'h3);
      run(KIND_VOLTAGE, 16'h0013, 0, 1, 0, 4'h5);
      run(KIND_VOLTAGE, 16'h0013, 1, 0, 1, 4'h5);
      run(KIND_TEMPERATURE, 16'h0041, 0, 0, 0, 4'h0);
      run(KIND_TEMPERATURE, 16'h007F, 2, 0, 0, 4'h1);
      end_of_test();
   end
endmodule : sensor_sample_request_port_tb
